// ==== dv/spsr_ctrl_model.sv ====
// Bus controller model issuing serial polls
`timescale 1ns/10ps
`default_nettype none
module spsr_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       poll_valid_i,
  input  wire logic [7:0] poll_byte_i,
  output var logic        serial_poll_o
);
  import spsr_pkg::*;
  initial serial_poll_o = 1'b0;
  // Byte taken only when flagged; otherwise unknown so the compare fails
  task automatic spoll(output logic [7:0] b);
    @(posedge clk_i);
    #1 serial_poll_o = 1'b1;
    @(posedge clk_i);
    #1 serial_poll_o = 1'b0;
    b = poll_valid_i ? poll_byte_i : 8'hXX;
  endtask
  task automatic wait_ready(output logic [7:0] b);
    for (int n = 0; n < 20; n++) begin
      spoll(b);
      if (b[STB_READY] === 1'b1) break;
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/spsr_status_properties.sv ====
// Port checker of the serial poll status block
`timescale 1ns/10ps
`default_nettype none
module spsr_status_properties (
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  input wire logic                    serial_poll_i,
  input wire spsr_pkg::spsr_cmd_type  cmd_i,
  input wire spsr_pkg::spsr_cond_type cond_i,
  input wire logic [7:0]              poll_byte_o,
  input wire logic                    poll_valid_o,
  input wire logic [7:0]              resp_byte_o,
  input wire logic                    resp_valid_o,
  input wire logic [7:0]              status_byte_o,
  input wire logic [7:0]              event_status_o,
  input wire logic [7:0]              service_request_mask_o,
  input wire logic                    ready_o,
  input wire logic                    srq_out_o,
  input wire logic                    srq_oe_b_o
);
  import spsr_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////////
  a_poll_answer: assert property (serial_poll_i |=> poll_valid_o &&
    poll_byte_o == status_byte_o) else $error("poll answer wrong");
  a_read_answer: assert property (cmd_i.status_byte_read_cmd |=> resp_valid_o &&
    resp_byte_o == status_byte_o) else $error("status read answer wrong");
  a_event_read: assert property (cmd_i.event_status_read_cmd &&
    !cmd_i.status_byte_read_cmd |=> resp_valid_o && resp_byte_o == event_status_o)
    else $error("event read answer wrong");
  a_srq_follows: assert property (status_byte_o[STB_RQS] == !$past(srq_oe_b_o))
    else $error("request line and request bit disagree");
  a_srq_level: assert property (srq_out_o == 1'b0)
    else $error("request line driven high");
  // Request may only rise from an enabled bit, the request bit itself excluded
  a_mask_gates: assert property ($rose(status_byte_o[STB_RQS]) |->
    $past((status_byte_o & service_request_mask_o & 8'hBF) != 8'h00))
    else $error("request raised without enabled bit");
  a_ready_copy: assert property (ready_o == status_byte_o[STB_READY])
    else $error("ready copy differs");
  a_line_busy: assert property (cond_i.line_start && !cond_i.line_done &&
    !cmd_i.restore_defaults |-> ##2 !ready_o) else $error("ready during line");
endmodule
bind spsr_status spsr_status_properties spsr_status_properties_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .serial_poll_i(serial_poll_i), .cmd_i(cmd_i),
  .cond_i(cond_i), .poll_byte_o(poll_byte_o), .poll_valid_o(poll_valid_o),
  .resp_byte_o(resp_byte_o), .resp_valid_o(resp_valid_o), .status_byte_o(status_byte_o),
  .event_status_o(event_status_o), .service_request_mask_o(service_request_mask_o),
  .ready_o(ready_o), .srq_out_o(srq_out_o), .srq_oe_b_o(srq_oe_b_o));
`default_nettype wire

// ==== dv/spsr_status_test.sv ====
// Self-checking bench of the serial poll status block
`timescale 1ns/10ps
`default_nettype none
module spsr_status_test;
  import spsr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic alarm_pin_i = 1'b0;
  logic serial_poll;
  spsr_cmd_type cmd_i = '0;
  spsr_cond_type cond_i = '0;
  logic [7:0] poll_byte, resp_byte, stb, esr_v, sre_v, ese_v;
  logic poll_valid, resp_valid, ready, srq_out, srq_oe_b;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h8E7246A6;
  logic alm = 0, trig = 0, rdy = 0, scan = 0, message_available_bit = 0, ovr = 0, rqs = 0, prev = 0;
  logic [7:0] event_status_bits = 8'h00, event_status_mask = 8'h00, service_request_mask = 8'h00;
  ////////////////////////////////////////////////////////////////////////////////
  spsr_status spsr_status_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .alarm_pin_i(alarm_pin_i),
    .serial_poll_i(serial_poll), .cmd_i(cmd_i), .cond_i(cond_i), .poll_byte_o(poll_byte),
    .poll_valid_o(poll_valid), .resp_byte_o(resp_byte), .resp_valid_o(resp_valid),
    .status_byte_o(stb), .event_status_o(esr_v), .service_request_mask_o(sre_v),
    .event_status_mask_o(ese_v), .ready_o(ready), .srq_out_o(srq_out),
    .srq_oe_b_o(srq_oe_b));
  spsr_ctrl_model spsr_ctrl_model_i (.clk_i(clk_i), .poll_valid_i(poll_valid),
    .poll_byte_i(poll_byte), .serial_poll_o(serial_poll));
  always #20 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_b();
    return {ovr, rqs, |(event_status_bits & event_status_mask), message_available_bit, scan, rdy, trig, alm};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request is raised on a rising summary only, so a held summary stays quiet
  task automatic upd();
    logic s;
    s = |(exp_b() & service_request_mask & 8'hBF);
    if (s && !prev) rqs = 1'b1;
    prev = s;
  endtask
  // Pulses last one cycle; levels follow the model, then the design settles
  task automatic go(input spsr_cmd_type c, input spsr_cond_type d);
    @(posedge clk_i);
    #1 cmd_i = c;
    cond_i = d;
    cond_i.scan_unread = scan;
    cond_i.queue_nonempty = message_available_bit;
    @(posedge clk_i);
    #1 cmd_i = '0;
    cond_i = '0;
    cond_i.scan_unread = scan;
    cond_i.queue_nonempty = message_available_bit;
    repeat (6) @(posedge clk_i);
  endtask
  // Outputs are read one step after the edge, except the request line check on entry
  task automatic poll();
    logic [7:0] b;
    chk({6'h00, srq_out, srq_oe_b}, {7'h00, !rqs});
    spsr_ctrl_model_i.spoll(b);
    chk(b, exp_b());
    rqs = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk(stb, exp_b());
    chk({6'h00, srq_out, srq_oe_b}, 8'h01);
    chk(esr_v, event_status_bits);
    chk(sre_v, service_request_mask);
    chk(ese_v, event_status_mask);
  endtask
  task automatic end_of_test();
    $display("num_errors %0d checked %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] b, exp;
    logic [31:0] r;
    spsr_cmd_type c;
    spsr_cond_type d;
    repeat (12) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    rdy = 1'b1;
    repeat (4) @(posedge clk_i);
    poll();
    spsr_ctrl_model_i.wait_ready(b);
    chk(b & 8'h04, 8'h04);
    for (int k = 0; k < 3; k++) begin
      d = '0;
      d.line_start = (k == 0);
      d.line_exec = (k == 1);
      d.line_done = (k == 2);
      rdy = (k == 2);
      go('0, d);
      poll();
    end
    for (int i = 0; i < 90; i++) begin
      r = rnd();
      c = '0;
      d = '0;
      c.mask_data = r[23:16];
      exp = exp_b();
      case (r[2:0])
        3'd0: begin
          alarm_pin_i = r[8];
          alm = r[8];
        end
        3'd1: begin
          d.trigger_detect = r[8];
          d.acq_complete = r[9];
          c.trigger_reconfig = r[10];
          trig = r[8] | (trig & !(r[9] | r[10]));
        end
        3'd2: begin
          scan = r[8];
          message_available_bit = r[9];
        end
        3'd3: begin
          d.buffer_overrun = r[8];
          d.buffer_empty = r[9];
          c.buffer_reset = r[10];
          ovr = r[8] | (ovr & !(r[9] | r[10]));
        end
        3'd4: begin
          d.event_set = r[15:8];
          c.error_query = r[16];
          event_status_bits = (r[16] ? event_status_bits & ~ESR_ERR_MASK : event_status_bits) | r[15:8];
        end
        3'd5: begin
          c.set_request_mask_cmd = r[8];
          c.set_event_mask_cmd = r[9];
          service_request_mask = r[8] ? r[23:16] : service_request_mask;
          event_status_mask = r[9] ? r[23:16] : event_status_mask;
        end
        3'd6: begin
          c.status_byte_read_cmd = 1'b1;
          c.event_status_read_cmd = r[8];
        end
        default: begin
          c.event_status_read_cmd = 1'b1;
        end
      endcase
      go(c, d);
      if (r[2:0] == 3'd6) begin
        chk(resp_byte, exp);
        trig = 1'b0;
        ovr = 1'b0;
        rqs = 1'b0;
        prev = 1'b0;
      end
      if (r[2:0] == 3'd7) chk(resp_byte, event_status_bits);
      upd();
      poll();
    end
    c = '0;
    c.restore_defaults = 1'b1;
    go(c, '0);
    {trig, ovr, rqs, prev, event_status_bits, event_status_mask, service_request_mask} = '0;
    upd();
    poll();
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== hdl/spsr_flag.sv ====
// One status flag with set, clear and a choice of which one wins
`timescale 1ns/10ps
`default_nettype none
module spsr_flag #(
  parameter bit SET_WINS = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_d;

  always_comb begin
    if (SET_WINS) begin
      flag_d = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_o);
    end else begin
      flag_d = clr_i ? 1'b0 : (set_i ? 1'b1 : flag_o);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_d;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/spsr_pkg.sv ====
// Package: constants and carrier types for the serial poll status block
package spsr_pkg;

  // Status byte bit positions (weights 1,2,4,...,128)
  localparam int unsigned STB_ALARM    = 0;
  localparam int unsigned STB_TRIG     = 1;
  localparam int unsigned STB_READY    = 2;
  localparam int unsigned STB_SCAN     = 3;
  localparam int unsigned STB_MAV      = 4;
  localparam int unsigned STB_ESB      = 5;
  localparam int unsigned STB_RQS      = 6;
  localparam int unsigned STB_OVERRUN  = 7;

  // Bits whose set wins over a clear in the same cycle
  localparam logic [7:0] STB_SET_WINS  = 8'hC2;

  // Event status bit positions of the three error indications
  localparam int unsigned ESR_DEV_ERR  = 3;
  localparam int unsigned ESR_EXE_ERR  = 4;
  localparam int unsigned ESR_CMD_ERR  = 5;
  localparam logic [7:0] ESR_ERR_MASK  = 8'h38;

  // Values after reset
  localparam logic [7:0] STB_RESET     = 8'h00;
  localparam logic [7:0] ESR_RESET     = 8'h00;
  localparam logic [7:0] SRE_RESET     = 8'h00;
  localparam logic [7:0] ESE_RESET     = 8'h00;

  // Command line progress
  typedef enum logic [1:0] {
    SPSR_ST_READY = 2'b00,
    SPSR_ST_PARSE = 2'b01,
    SPSR_ST_EXEC  = 2'b11
  } spsr_line_state_type;

  // Commands decoded by the device's command parser, one-cycle pulses
  typedef struct packed {
    logic       restore_defaults;
    logic       status_byte_read_cmd;
    logic       event_status_read_cmd;
    logic       error_query;
    logic       set_request_mask_cmd;
    logic       set_event_mask_cmd;
    logic       buffer_reset;
    logic       trigger_reconfig;
    logic [7:0] mask_data;
  } spsr_cmd_type;

  // Device conditions from the same clock domain
  typedef struct packed {
    logic       trigger_detect;
    logic       acq_complete;
    logic       scan_unread;
    logic       queue_nonempty;
    logic       buffer_overrun;
    logic       buffer_empty;
    logic       line_start;
    logic       line_exec;
    logic       line_done;
    logic [7:0] event_set;
  } spsr_cond_type;

endpackage

// ==== hdl/spsr_status.sv ====
// Serial poll status byte, event status and service request logic
//
// How it works
// - Serial poll returns current status byte
// - Bits track conditions; mask gates requests
// - Bit weights alarm 1 through overrun 128
// - Restore or status read clears all bits except a same-cycle trigger, request or overrun set
// - Event summary cleared by restore, read
// - Error query clears three error indications
// - Alarm bit follows sensed alarm condition
// - Trigger set on detect, cleared on done
// - Ready set idle, cleared while processing
// - Ready returns after execute fully processed
// - Scan bit set while unread scans exist
// - Message bit set while queue non-empty
// - Summary is OR of masked events
// - Event status read returns event register
// - Request bit set, cleared by serial poll
// - Overrun set on overrun, cleared when empty
// - Masked status bits ORed to request summary
// - Request mask alters no stored bit except the request bit
`timescale 1ns/10ps
`default_nettype none
module spsr_status (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   alarm_pin_i,
  input  wire logic                   serial_poll_i,
  input  wire spsr_pkg::spsr_cmd_type cmd_i,
  input  wire spsr_pkg::spsr_cond_type cond_i,
  output logic [7:0]                  poll_byte_o,
  output logic                        poll_valid_o,
  output logic [7:0]                  resp_byte_o,
  output logic                        resp_valid_o,
  output logic [7:0]                  status_byte_o,
  output logic [7:0]                  event_status_o,
  output logic [7:0]                  service_request_mask_o,
  output logic [7:0]                  event_status_mask_o,
  output logic                        ready_o,
  output logic                        srq_out_o,
  output logic                        srq_oe_b_o
);
  import spsr_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic                alarm_meta_q;
  logic                alarm_sync_q;
  spsr_line_state_type line_q;
  spsr_line_state_type line_d;
  logic [7:0]          stb;
  logic [7:0]          stb_set;
  logic [7:0]          stb_clr;
  logic [7:0]          event_status_bits;
  logic [7:0]          esr_set;
  logic [7:0]          esr_clr;
  logic [7:0]          sre_q;
  logic [7:0]          ese_q;
  logic                esb_cond;
  logic                summary;
  logic                summary_q;
  logic                line_idle;
  logic                stb_wipe;

  ////////////////////////////////////////////////////////////////////
  // Alarm comes from a pin, so it is synchronised first

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_meta_q <= 1'b0;
      alarm_sync_q <= 1'b0;
    end else begin
      alarm_meta_q <= alarm_pin_i;
      alarm_sync_q <= alarm_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Command line progress

  always_comb begin
    line_d = line_q;
    case (line_q)
      SPSR_ST_READY: begin
        if (cond_i.line_start) begin
          line_d = SPSR_ST_PARSE;
        end
      end
      SPSR_ST_PARSE: begin
        if (cond_i.line_exec) begin
          line_d = SPSR_ST_EXEC;
        end
      end
      SPSR_ST_EXEC: begin
        // Only the end of the execute step, or a restore, frees the parser
        if (cond_i.line_done) begin
          line_d = SPSR_ST_READY;
        end
      end
      default: begin
        line_d = SPSR_ST_READY;
      end
    endcase
    if (cmd_i.restore_defaults) begin
      line_d = SPSR_ST_READY;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_q <= SPSR_ST_READY;
    end else begin
      line_q <= line_d;
    end
  end

  // Ready only while no line is in flight
  assign line_idle = (line_q == SPSR_ST_READY) && !cond_i.line_start;

  ////////////////////////////////////////////////////////////////////
  // Masks written by the set-mask commands

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sre_q <= SRE_RESET;
    end else if (cmd_i.restore_defaults) begin
      sre_q <= SRE_RESET;
    end else if (cmd_i.set_request_mask_cmd) begin
      sre_q <= cmd_i.mask_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ese_q <= ESE_RESET;
    end else if (cmd_i.restore_defaults) begin
      ese_q <= ESE_RESET;
    end else if (cmd_i.set_event_mask_cmd) begin
      ese_q <= cmd_i.mask_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event status register

  always_comb begin
    esr_set = cond_i.event_set;
    esr_clr = {8{cmd_i.restore_defaults}};
    if (cmd_i.error_query) begin
      esr_clr = esr_clr | ESR_ERR_MASK;
    end
  end

  // An event in the clearing cycle is kept
  for (genvar e = 0; e < 8; e++) begin : g_esr
    spsr_flag #(
      .SET_WINS (1'b1)
    ) u_esr (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .set_i   (esr_set[e]),
      .clr_i   (esr_clr[e]),
      .flag_o  (event_status_bits[e])
    );
  end

  assign esb_cond = |(event_status_bits & ese_q);

  ////////////////////////////////////////////////////////////////////
  // Status byte set and clear terms

  // Both clearing commands wipe the byte
  assign stb_wipe = cmd_i.restore_defaults | cmd_i.status_byte_read_cmd;

  // Tracking bits let the clear win, so a read drops them for one
  // cycle and a still present condition sets them again
  always_comb begin
    stb_set = 8'h00;
    stb_clr = {8{stb_wipe}};
    stb_set[STB_ALARM]   = alarm_sync_q;
    stb_clr[STB_ALARM]   = stb_wipe | !alarm_sync_q;
    stb_set[STB_TRIG]    = cond_i.trigger_detect;
    stb_clr[STB_TRIG]    = stb_wipe | cond_i.acq_complete
                         | cmd_i.trigger_reconfig;
    stb_set[STB_READY]   = line_idle;
    stb_clr[STB_READY]   = stb_wipe | !line_idle;
    stb_set[STB_SCAN]    = cond_i.scan_unread;
    stb_clr[STB_SCAN]    = stb_wipe | !cond_i.scan_unread;
    stb_set[STB_MAV]     = cond_i.queue_nonempty;
    stb_clr[STB_MAV]     = stb_wipe | !cond_i.queue_nonempty;
    stb_set[STB_ESB]     = esb_cond;
    stb_clr[STB_ESB]     = stb_wipe | !esb_cond;
    stb_set[STB_RQS]     = summary && !summary_q && !stb[STB_RQS];
    stb_clr[STB_RQS]     = stb_wipe | serial_poll_i;
    stb_set[STB_OVERRUN] = cond_i.buffer_overrun;
    stb_clr[STB_OVERRUN] = stb_wipe | cond_i.buffer_empty
                         | cmd_i.buffer_reset;
  end

  // Status bits other than the request bit never see the request mask
  for (genvar b = 0; b < 8; b++) begin : g_stb
    spsr_flag #(
      .SET_WINS (STB_SET_WINS[b])
    ) u_stb (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .set_i   (stb_set[b]),
      .clr_i   (stb_clr[b]),
      .flag_o  (stb[b])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Masked summary and the request line

  // Own request bit left out so it cannot feed itself
  always_comb begin
    logic [7:0] gated;
    gated = stb & sre_q;
    gated[STB_RQS] = 1'b0;
    summary = |gated;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= summary;
    end
  end

  // Open-drain line: pull low while a request stands
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      srq_oe_b_o <= 1'b1;
      srq_out_o  <= 1'b0;
    end else begin
      srq_oe_b_o <= !stb_set[STB_RQS] && (stb_clr[STB_RQS] || !stb[STB_RQS]);
      srq_out_o  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial poll answer

  // Byte is the one standing when the poll arrives
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      poll_byte_o  <= STB_RESET;
      poll_valid_o <= 1'b0;
    end else begin
      poll_valid_o <= serial_poll_i;
      if (serial_poll_i) begin
        poll_byte_o <= stb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Responses to the status read commands

  // Status read takes the byte before the wipe lands
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resp_byte_o  <= 8'h00;
      resp_valid_o <= 1'b0;
    end else begin
      resp_valid_o <= cmd_i.status_byte_read_cmd
                   | cmd_i.event_status_read_cmd;
      if (cmd_i.status_byte_read_cmd) begin
        resp_byte_o <= stb;
      end else if (cmd_i.event_status_read_cmd) begin
        resp_byte_o <= event_status_bits;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered views for the rest of the device

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_byte_o          <= STB_RESET;
      event_status_o         <= ESR_RESET;
      service_request_mask_o <= SRE_RESET;
      event_status_mask_o    <= ESE_RESET;
      ready_o                <= 1'b0;
    end else begin
      status_byte_o          <= stb;
      event_status_o         <= event_status_bits;
      service_request_mask_o <= sre_q;
      event_status_mask_o    <= ese_q;
      ready_o                <= stb[STB_READY];
    end
  end

endmodule
`default_nettype wire
